/* hw/tag_resp_cfg.svh */
/*
  Constants of the system-information and security-status responder:
  register offsets, reset values, opcodes, codes and fixed answer bytes.
  Assumes inclusion by bare name before the package and design module.
*/
`ifndef TAG_RESP_CFG_SVH
`define TAG_RESP_CFG_SVH

`define OFF_DSFID      10'h000
`define OFF_AFI        10'h004
`define OFF_LAST_BLK   10'h008
`define OFF_UID_LO     10'h00C
`define OFF_UID_HI     10'h010
`define OFF_STATUS     10'h014
`define OFF_BSS_BASE   10'h200

`define RST_DSFID      8'h00
`define RST_AFI        8'h00
`define RST_UID        64'h0000000000000000

`define OP_SYSINFO     8'h2B
`define OP_MBSS        8'h2C
`define OP_EXTINFO     8'h3B

`define FLAGS_BAD_MASK 8'hCC
`define ADDR_FLAG_BIT  5
`define LIST_MOI_BIT   4
`define LIST_EXT_BIT   7

`define LEN_SYSINFO    4'h2
`define LEN_MBSS       4'h4
`define LEN_EXTINFO    4'h3
`define LEN_UID        4'h8
`define UID_POS_SYS    4'h2
`define UID_POS_EXT    4'h3
`define LEN_OVERFLOW   4'hD

`define RFLAGS_OK      8'h00
`define RFLAGS_ERR     8'h01
`define ERR_FORMAT     8'h02
`define ERR_FLAGS      8'h03
`define ERR_BLOCK      8'h10
`define SYS_IFLAGS     8'h0F
`define BLOCK_SIZE_M1  8'h03
`define CMD_LIST       32'h00003FEF

`endif

/* hw/tag_resp_pkg.sv */
/*
  Types of the responder: request beats, answer beats, register port,
  phase and answer-section enumerations.
  Assumes tag_resp_cfg.svh is on the include path.
*/
`default_nettype none

package tag_resp_pkg;

  typedef struct packed {
    logic       valid;
    logic       eof;
    logic [7:0] data;
  } rx_beat_s;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic       read_timing;
    logic [7:0] data;
  } tx_beat_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef enum logic [0:0] {
    PH_COLLECT = 1'b0,
    PH_SEND    = 1'b1
  } phase_e;

  typedef enum logic [3:0] {
    SEC_RFL  = 4'h0,
    SEC_IFL  = 4'h1,
    SEC_UID  = 4'h2,
    SEC_DSF  = 4'h3,
    SEC_AFI  = 4'h4,
    SEC_MEM  = 4'h5,
    SEC_ICR  = 4'h6,
    SEC_CMD  = 4'h7,
    SEC_ERR  = 4'h8,
    SEC_BSS  = 4'h9,
    SEC_NONE = 4'hF
  } sec_e;

endpackage

`default_nettype wire

/* hw/tag_sysinfo_security_responder.sv */
/*
  Responder for the system-info, multiple block security status and
  extended system-info requests of a vicinity tag.
  Assumes the front end delivers decoded, CRC-checked request bytes on mclk,
  then one eof beat, and appends CRC and framing to the answer bytes.
*/
// The plain strobed port and the register addresses were chosen for this implementation.
`include "tag_resp_cfg.svh"
`default_nettype none

// Contract
// - Identifier field accepted in a request only when the address flag is set.
// - System-info answer: flags 00h, info flags 0Fh, UID, DSFID, AFI, size, reference.
// - Upper memory-size byte is block size minus one, 03h.
// - Lower memory-size byte is the last-user-block setting.
// - System-info faults answer 02h for format, 03h for flags.
// - All three answers use read-type response timing.
// - Security request needs an existing first block, else 10h; 02h/03h faults.
// - Security range past user memory is cut at the last block.
// - Security answer: flags 00h, one status byte per block, ascending.
// - List bits 0,1,2,3,5,6 request DSFID, AFI, size, reference, commands, CSI; the code ignores bit 6 and sends no CSI.
// - Memory organisation information is always reported.
// - Info flag bits mark present fields, appended in fixed order.
// - Extended info flags keep bits 4, 6 and 7 cleared.
// - Command list requested returns 00003FEFh and sets info flag bit 5.
// - Extended size: block size minus one on top, block count minus one below.
// - Extended faults answer 02h for format, 03h for flags or list.
module tag_sysinfo_security_responder #(
  parameter int         NBLK   = 80,
  parameter logic [7:0] IC_REF = 8'h5A  // Arbitrary value
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire tag_resp_pkg::rx_beat_s rx,
  input  wire logic                  tx_ready,
  output var  tag_resp_pkg::tx_beat_s tx,
  input  wire tag_resp_pkg::reg_req_s req,
  output var  logic [31:0]           rdata
);
  import tag_resp_pkg::*;

  typedef struct packed {
    phase_e               ph;
    logic [11:0][7:0]     rbuf;
    logic [3:0]           cnt;
    sec_e                 sec;
    logic [7:0]           sub;
    sec_e                 tsec;
    logic [7:0]           tsub;
    logic [9:0]           mask;
    logic                 ext;
    logic [7:0]           start;
    logic [7:0]           n;
    logic [7:0]           list;
    logic [7:0]           err;
    logic [7:0]           dsfid;
    logic [7:0]           afi;
    logic [7:0]           last_blk;
    logic [63:0]          uid;
    logic [NBLK-1:0][7:0] block_security_byte;
    logic [31:0]          rdata;
    tx_beat_s             tx;
  } state_s;

  state_s q;
  state_s d;

  // Last byte index of a section
  function automatic logic [7:0] sec_last(input state_s s);
    unique case (s.sec)
      SEC_UID: sec_last = 8'h07;
      SEC_MEM: sec_last = s.ext ? 8'h02 : 8'h01;
      SEC_CMD: sec_last = 8'h03;
      SEC_BSS: sec_last = s.n;
      default: sec_last = 8'h00;
    endcase
  endfunction

  // Next present section after the current one
  function automatic sec_e next_sec(input state_s s);
    logic found;
    found    = 1'b0;
    next_sec = SEC_NONE;
    for (int i = 0; i < 10; i++)
    begin
      if (!found && i > int'(s.sec) && s.mask[i])
      begin
        next_sec = sec_e'(4'(i));
        found    = 1'b1;
      end
    end
  endfunction

  // Answer byte for the current section and index; multi-byte fields LSB first
  function automatic logic [7:0] byte_at(input state_s s);
    logic [63:0] sh;
    logic [31:0] cl;
    sh = s.uid >> {s.sub[2:0], 3'b000};
    cl = `CMD_LIST >> {s.sub[1:0], 3'b000};
    unique case (s.sec)
      SEC_RFL: byte_at = s.mask[SEC_ERR] ? `RFLAGS_ERR : `RFLAGS_OK;
      SEC_IFL: byte_at = s.ext ? {2'b00, s.list[5], 1'b0, s.list[3:0]}
                               : `SYS_IFLAGS;
      SEC_UID: byte_at = sh[7:0];
      SEC_DSF: byte_at = s.dsfid;
      SEC_AFI: byte_at = s.afi;
      SEC_MEM: byte_at = (s.sub == 8'h00) ? s.last_blk
                       : (s.sub == 8'h01 && s.ext) ? 8'h00
                       : `BLOCK_SIZE_M1;
      SEC_ICR: byte_at = IC_REF;
      SEC_CMD: byte_at = cl[7:0];
      SEC_ERR: byte_at = s.err;
      SEC_BSS: byte_at = s.block_security_byte[8'(s.start + s.sub)];
      default: byte_at = 8'h00;
    endcase
  endfunction

  always_comb
  begin
    logic [7:0]  flags;
    logic [7:0]  op;
    logic        addr;
    logic        ours;
    logic [3:0]  len;
    logic [3:0]  upos;
    logic [63:0] uid_rx;
    logic [7:0]  add;
    logic [8:0]  stop;
    logic [7:0]  code;
    logic [7:0]  lastsub;
    sec_e        nx;
    flags   = q.rbuf[0];
    op      = q.rbuf[1];
    addr    = flags[`ADDR_FLAG_BIT];
    ours    = 1'b1;
    len     = `LEN_SYSINFO;
    upos    = `UID_POS_SYS;
    uid_rx  = '0;
    add     = 8'h00;
    stop    = 9'h000;
    code    = 8'h00;
    lastsub = 8'h00;
    nx      = SEC_NONE;
    d       = q;
    d.rdata = '0;

    // Register port
    if (req.rd)
    begin
      if ((req.addr & `OFF_BSS_BASE) != 10'h000)
      begin
        if (int'(req.addr[8:2]) < NBLK)
          d.rdata = {24'h000000, q.block_security_byte[req.addr[8:2]]};
      end
      else
      begin
        unique case (req.addr)
          `OFF_DSFID:    d.rdata = {24'h000000, q.dsfid};
          `OFF_AFI:      d.rdata = {24'h000000, q.afi};
          `OFF_LAST_BLK: d.rdata = {24'h000000, q.last_blk};
          `OFF_UID_LO:   d.rdata = q.uid[31:0];
          `OFF_UID_HI:   d.rdata = q.uid[63:32];
          `OFF_STATUS:   d.rdata = {23'h000000, q.err, q.ph};
          default:       d.rdata = '0;
        endcase
      end
    end
    if (req.wr)
    begin
      if ((req.addr & `OFF_BSS_BASE) != 10'h000)
      begin
        if (int'(req.addr[8:2]) < NBLK)
          d.block_security_byte[req.addr[8:2]] = req.wdata[7:0];
      end
      else
      begin
        unique case (req.addr)
          `OFF_DSFID:    d.dsfid    = req.wdata[7:0];
          `OFF_AFI:      d.afi      = req.wdata[7:0];
          `OFF_LAST_BLK: d.last_blk = req.wdata[7:0];
          `OFF_UID_LO:   d.uid[31:0]  = req.wdata;
          `OFF_UID_HI:   d.uid[63:32] = req.wdata;
          default:       d.dsfid    = q.dsfid;
        endcase
      end
    end

    if (q.tx.valid && tx_ready)
      d.tx.valid = 1'b0;

    unique case (q.ph)
      PH_COLLECT:
      begin
        if (rx.valid)
        begin
          if (q.cnt < 4'hC)
            d.rbuf[q.cnt] = rx.data;
          d.cnt = (q.cnt == `LEN_OVERFLOW) ? q.cnt : q.cnt + 4'h1;
        end
        else if (rx.eof)
        begin
          d.cnt = 4'h0;
          unique case (op)
            `OP_SYSINFO: len = `LEN_SYSINFO;
            `OP_MBSS:    len = `LEN_MBSS;
            `OP_EXTINFO:
            begin
              len  = `LEN_EXTINFO;
              upos = `UID_POS_EXT;
            end
            default:     ours = 1'b0;
          endcase
          len = addr ? len + `LEN_UID : len;
          for (int k = 0; k < 8; k++)
            uid_rx[k*8 +: 8] = q.rbuf[4'(upos + 4'(k))];
          d.start = q.rbuf[4'(len - 4'h2)];
          add     = q.rbuf[4'(len - 4'h1)];
          d.list  = q.rbuf[2];
          stop    = {1'b0, d.start} + {1'b0, add};
          if (stop > {1'b0, q.last_blk})
            stop = {1'b0, q.last_blk};
          d.n   = stop[7:0] - d.start;
          d.ext = (op == `OP_EXTINFO);
          if ((flags & `FLAGS_BAD_MASK) != 8'h00)
            code = `ERR_FLAGS;
          else if (q.cnt != len)
            code = `ERR_FORMAT;
          else if (d.ext && (!d.list[`LIST_MOI_BIT] || d.list[`LIST_EXT_BIT]))
            code = `ERR_FLAGS;
          else if (op == `OP_MBSS && d.start > q.last_blk)
            code = `ERR_BLOCK;
          if (q.cnt >= 4'h2 && ours
              && !(addr && q.cnt == len && uid_rx != q.uid))
          begin
            d.err = code;
            d.ph  = PH_SEND;
            d.sec = SEC_RFL;
            d.sub = 8'h00;
            if (code != 8'h00)
              d.mask = 10'h101;
            else if (op == `OP_MBSS)
              d.mask = 10'h201;
            else if (d.ext)
              d.mask = {2'b00, d.list[5], d.list[3:0], 3'b111};
            else
              d.mask = 10'h07F;
          end
        end
      end
      PH_SEND:
      begin
        if (!q.tx.valid || tx_ready)
        begin
          lastsub          = sec_last(q);
          nx               = next_sec(q);
          d.tx.valid       = 1'b1;
          d.tx.read_timing = 1'b1;
          d.tx.data        = byte_at(q);
          d.tx.last        = (q.sub == lastsub) && (nx == SEC_NONE);
          d.tsec           = q.sec;
          d.tsub           = q.sub;
          if (q.sub != lastsub)
            d.sub = q.sub + 8'h01;
          else if (nx == SEC_NONE)
            d.ph = PH_COLLECT;
          else
          begin
            d.sec = nx;
            d.sub = 8'h00;
          end
        end
      end
      default: d.ph = PH_COLLECT;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      q          <= '0;
      q.dsfid    <= `RST_DSFID;
      q.afi      <= `RST_AFI;
      q.uid      <= `RST_UID;
      q.last_blk <= 8'(NBLK - 1);
    end
    else
      q <= d;
  end

  assign tx    = q.tx;
  assign rdata = q.rdata;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_read_timing: assert property (tx.valid |-> tx.read_timing)
    else $error("answer byte without read-type timing");
  a_sys_iflags: assert property (tx.valid && q.tsec == SEC_IFL && !q.ext
    |-> tx.data == 8'h0F) else $error("system info flags not 0Fh");
  a_mem_top: assert property (tx.valid && q.tsec == SEC_MEM && q.tsub != 8'h00
    |-> tx.data == (q.ext && q.tsub == 8'h01 ? 8'h00 : 8'h03))
    else $error("memory size upper byte wrong");
  a_mem_low: assert property (tx.valid && q.tsec == SEC_MEM && q.tsub == 8'h00
    |-> tx.data == q.last_blk) else $error("memory size lower byte wrong");
  a_err_single: assert property (tx.valid && q.tsec == SEC_ERR
    |-> tx.last && q.mask == 10'h101) else $error("error answer carries more bytes");
  a_err_code: assert property (tx.valid && q.tsec == SEC_ERR
    |-> tx.data inside {8'h02, 8'h03, 8'h10}) else $error("unknown error code");
  a_ext_flags: assert property (tx.valid && q.tsec == SEC_IFL && q.ext
    |-> tx.data[7:6] == 2'b00 && !tx.data[4]) else $error("extended flag bits set");
  a_cmd_list: assert property (tx.valid && q.tsec == SEC_CMD && q.tsub == 8'h00
    |-> tx.data == 8'hEF && q.mask[SEC_CMD]) else $error("command list byte wrong");
  a_bss_range: assert property (tx.valid && q.tsec == SEC_BSS
    |-> 9'(q.start) + 9'(q.tsub) <= 9'(q.last_blk)) else $error("status past last block");
  a_bss_order: assert property (tx.valid && tx_ready && q.tsec == SEC_BSS && !tx.last
    |=> tx.valid && q.tsub == $past(q.tsub) + 8'h01) else $error("status bytes out of order");
endmodule

`default_nettype wire

/* verification/reader_model.sv */
/*
  Reader side of the responder: sends request frames byte by byte
  and accepts answer bytes with random stalls.
  Assumes mclk and an active-high synchronous rst from the bench.
*/
`default_nettype none

module reader_model (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  output var  tag_resp_pkg::rx_beat_s rx,
  output var  logic                  tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import tag_resp_pkg::*;

  initial rx = '0;
  initial tx_ready = 1'b0;

  // Random stall of the answer stream
  always @(posedge mclk)
    tx_ready <= rst ? 1'b0 : ($urandom_range(3) != 0);

  // Bytes, then one eof beat; data never left showing the last byte
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      @(posedge mclk);
      rx <= '{1'b1, 1'b0, b[i]};
    end
    @(posedge mclk);
    rx <= '{1'b0, 1'b1, ~b[b.size()-1]};
    @(posedge mclk);
    rx <= '{1'b0, 1'b0, b[b.size()-1] ^ 8'h5A};
  endtask
endmodule

`default_nettype wire

/* verification/tb.sv */
/*
  Self-checking bench of the responder: register set-up, then
  system-info, security-status and extended requests.
  Assumes the reader model drives the request link and tx_ready.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tag_resp_pkg::*;

  localparam logic [7:0] IC = 8'h5A;  // Arbitrary value
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  rx_beat_s    rx;
  logic        tx_ready;
  tx_beat_s    tx;
  reg_req_s    req;
  logic [31:0] rdata;
  int          bad_count = 0;
  int          checks_done = 0;
  int          frames_done = 0;
  logic [9:0]  expq[$];
  logic [7:0]  stg[$];
  logic [7:0]  fr[$];
  logic [63:0] uid;
  logic [7:0]  dsf;
  logic [7:0]  afi;
  logic [7:0]  lb;
  logic [7:0]  lst;
  logic [7:0]  block_security_byte[10];
  logic [7:0]  tbl[8] = '{8'h10, 8'h11, 8'h12, 8'h14, 8'h18, 8'h30, 8'h7F, 8'h5F};

  always #25 mclk = ~mclk;

  tag_sysinfo_security_responder #(.NBLK(80), .IC_REF(IC)) tag_sysinfo_security_responder_i (
    .mclk(mclk), .rst(rst), .rx(rx), .tx_ready(tx_ready), .tx(tx), .req(req), .rdata(rdata));

  reader_model reader_model_i (.mclk(mclk), .rst(rst), .rx(rx), .tx_ready(tx_ready));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    req <= '0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge mclk);
    req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
    check(rdata, e);
  endtask

  task automatic ex(input logic [7:0] d);
    stg.push_back(d);
  endtask

  // Moves staged bytes to the expectation queue, last flag on the final one
  task automatic commit;
    logic [7:0] b;
    while (stg.size() != 0)
    begin
      b = stg.pop_front();
      expq.push_back({1'b1, stg.size() == 0, b});
    end
  endtask

  task automatic err(input logic [7:0] c);
    ex(8'h01);
    ex(c);
    commit();
  endtask

  task automatic uidx;
    for (int i = 0; i < 8; i++) ex(uid[8*i+:8]);
  endtask

  task automatic uidf;
    for (int i = 0; i < 8; i++) fr.push_back(uid[8*i+:8]);
  endtask

  task automatic exp_sys;
    ex(8'h00);
    ex(8'h0F);
    uidx();
    ex(dsf);
    ex(afi);
    ex(lb);
    ex(8'h03);
    ex(IC);
    commit();
  endtask

  task automatic run(input bit answered);
    int n;
    n = frames_done;
    reader_model_i.send(fr);
    fr.delete();
    for (int k = 0; k < 400 && frames_done == n; k++) @(posedge mclk);
    check(frames_done - n, answered);
    check(expq.size(), 0);
  endtask

  // Answer monitor
  always @(posedge mclk)
    if (!rst && tx.valid && tx_ready)
    begin
      check({22'h0, tx.read_timing, tx.last, tx.data},
            expq.size() != 0 ? {22'h0, expq.pop_front()} : 32'hFFFFFFFF);
      if (tx.last)
        frames_done++;
    end

  initial
  begin
    req = '0;
    void'($urandom(32'hd9e1));
    uid = {$urandom, $urandom};
    dsf = 8'($urandom);
    afi = 8'($urandom);
    lb = 8'h09;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    wr(10'h000, {24'h0, dsf});
    wr(10'h004, {24'h0, afi});
    wr(10'h008, {24'h0, lb});
    wr(10'h00C, uid[31:0]);
    wr(10'h010, uid[63:32]);
    for (int i = 0; i < 10; i++)
    begin
      block_security_byte[i] = 8'($urandom);
      wr(10'h200 + 10'(4 * i), {24'h0, block_security_byte[i]});
    end
    rd(10'h000, {24'h0, dsf});
    rd(10'h008, {24'h0, lb});
    rd(10'h300, 32'h0);
    fr = '{8'h02, 8'h2B};
    exp_sys();
    run(1'b1);
    fr = '{8'h22, 8'h2B};
    uidf();
    exp_sys();
    run(1'b1);
    fr = '{8'h22, 8'h2B};
    uidf();
    fr[5] = ~fr[5];
    run(1'b0);
    fr = '{8'h42, 8'h2B};
    err(8'h03);
    run(1'b1);
    fr = '{8'h02, 8'h2B, 8'h00};
    err(8'h02);
    run(1'b1);
    fr = '{8'h02, 8'h2C, 8'h07, 8'h05};
    ex(8'h00);
    for (int i = 7; i < 10; i++) ex(block_security_byte[i]);
    commit();
    run(1'b1);
    fr = '{8'h22, 8'h2C};
    uidf();
    fr.push_back(8'h00);
    fr.push_back(8'h01);
    ex(8'h00);
    ex(block_security_byte[0]);
    ex(block_security_byte[1]);
    commit();
    run(1'b1);
    fr = '{8'h02, 8'h2C, lb, 8'hFF};
    ex(8'h00);
    ex(block_security_byte[9]);
    commit();
    run(1'b1);
    fr = '{8'h02, 8'h2C, lb + 8'h01, 8'h00};
    err(8'h10);
    run(1'b1);
    fr = '{8'h02, 8'h2C, 8'h00};
    err(8'h02);
    run(1'b1);
    fr = '{8'h0A, 8'h2C, 8'h00, 8'h00};
    err(8'h03);
    run(1'b1);
    for (int k = 0; k < 9; k++)
    begin
      lst = k < 8 ? tbl[k] : ((8'($urandom) & 8'h6F) | 8'h10);
      fr = '{k[0] ? 8'h22 : 8'h02, 8'h3B, lst};
      if (k[0])
        uidf();
      ex(8'h00);
      ex({2'b00, lst[5], 1'b0, lst[3:0]});
      uidx();
      if (lst[0])
        ex(dsf);
      if (lst[1])
        ex(afi);
      if (lst[2])
        stg = {stg, lb, 8'h00, 8'h03};
      if (lst[3])
        ex(IC);
      if (lst[5])
        stg = {stg, 8'hEF, 8'h3F, 8'h00, 8'h00};
      commit();
      run(1'b1);
    end
    fr = '{8'h02, 8'h3B, 8'h0F};
    err(8'h03);
    run(1'b1);
    fr = '{8'h02, 8'h3B, 8'h90};
    err(8'h03);
    run(1'b1);
    fr = '{8'h02, 8'h3B};
    err(8'h02);
    run(1'b1);
    rd(10'h014, 32'h00000004);
    give_verdict();
  end

  initial
  begin
    #(50 * 40000);
    bad_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
